// >>> src/touch_acq_regs.svh
// Purpose: register map, field positions and reset values of the touch acquisition control block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef TOUCH_ACQ_REGS_SVH
`define TOUCH_ACQ_REGS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define TA_OFS_STATUS_WORD   8'h3C
`define TA_OFS_STATUS_CLEAR  8'h40
`define TA_OFS_IRQ_SET       8'h44
`define TA_OFS_IRQ_CLEAR     8'h48
`define TA_OFS_IRQ_MASK      8'h4C
`define TA_OFS_ACQ_START     8'h50
`define TA_OFS_ACQ_COUNT     8'h54
`define TA_OFS_SPREAD_CFG    8'h60
`define TA_OFS_RES_CTRL      8'h64

// ****************************************
// status bit positions
// ****************************************
`define TA_BIT_ENABLED       0
`define TA_BIT_CALIBRATING   1
`define TA_BIT_AUTO_CHANGE   2
`define TA_BIT_COUNT_READY   8
`define TA_BIT_ACQ_DONE      9
`define TA_BIT_ASSIST_CHANGE 23

// implemented event bits: 23, 9, 8, 2, 1
`define TA_EVENT_BITS        32'h0080_0306

// ****************************************
// field widths and reset values
// ****************************************
`define TA_SEL_W             2
`define TA_DEV_W             8
`define TA_RES_W             17
`define TA_PAIR_LSB          16
`define TA_RESET_WORD        32'h0000_0000
`define TA_LFSR_SEED         9'h1A5

`endif

// >>> src/touch_acq_pkg.sv
// Purpose: shared types of the touch acquisition control block
// Assumes: no header included, field widths written out here
// Notes:   none
package touch_acq_pkg;

   // one acquired count with the sensor pair it belongs to
   typedef struct packed {
      logic [7:0]  pair;
      logic [15:0] count;
   } acq_count_t;

   // acquisition sequencing
   typedef enum logic [0:0] {
      ACQ_IDLE,
      ACQ_RUN
   } acq_state_t;

endpackage

// >>> src/touch_acq_control_interface.sv
// Purpose: APB register front end of a capacitive touch acquisition module
// Assumes: acquisition engine runs on ref_clk; engine holds a count offer until taken
// Notes:   single-cycle APB slave, unmapped access answers pslverr
//
// Function
// (R1) calibrating bit follows calibration level
// (R2) enabled bit follows module enable
// (R3) writing one to clear register clears flag
// (R4) zero writes change no flag or mask
// (R5) enable-set write sets mask bits
// (R6) enable-clear write clears mask bits
// (R7) mask resets zero, one enables source
// (R8) interrupt high while unmasked flag set
// (R9) start write launches selected group acquisition
// (R10) start register reads back last selection
// (R11) count register gives count and pair
// (R12) pairs enabled only, strictly increasing index
// (R13) burst deviation bounded by configured maximum
// (R14) resistor bit selects resistive burst drive
// (R15) count-ready set when count is available
// (R16) done low while running, set on completion
`timescale 1ns/1ns
`include "touch_acq_regs.svh"
`default_nettype none

module touch_acq_control_interface #(
   parameter int PAIRS = 32
) (
   // clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     reset,
   // apb slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output var  logic [31:0]              prdata,
   output var  logic                     pready,
   output var  logic                     pslverr,
   // engine status
   input  wire logic                     module_enabled,
   input  wire logic                     calibrating,
   input  wire logic                     auto_status_change,
   input  wire logic                     assist_state_change,
   input  wire logic [PAIRS-1:0]         pair_enable,
   // acquisition control
   output var  logic                     acq_start,
   output var  logic [1:0]               group_select_code,
   input  wire logic                     acq_complete,
   // count offers from the engine
   input  wire logic                     count_offer_valid,
   input  wire touch_acq_pkg::acq_count_t count_offer,
   output var  logic                     count_take,
   // burst drive
   input  wire logic                     spread_enable,
   input  wire logic                     burst_pulse,
   input  wire logic                     burst_phase,
   output var  logic                     dev_negative,
   output var  logic [7:0]               dev_cycles,
   output var  logic [16:0]              burst_pin_bank_a_res,
   // interrupt
   output var  logic                     irq
);
   import touch_acq_pkg::*;

   // ****************************************
   // apb decode
   // ****************************************
   logic        setup_w;        // setup phase of a transfer
   logic        access_w;       // access phase completes this edge
   logic        wr_w;           // write completes
   logic        rd_w;           // read completes
   logic        mapped_w;       // address hits a register
   logic [31:0] rd_mux_w;       // read data selected in setup

   assign setup_w  = psel && !penable;
   assign access_w = psel && penable && pready;
   assign wr_w     = access_w && pwrite;
   assign rd_w     = access_w && !pwrite;

   // ****************************************
   // registers
   // ****************************************
   logic [31:0]         flags_r;      // sticky event flags
   logic [31:0]         mask_r;       // interrupt mask
   logic [31:0]         mask_nxt;     // mask after this cycle's writes
   logic [1:0]          sel_r;        // last written selection
   acq_count_t          count_r;      // presented count word
   logic [7:0]          burst_max_deviation_r;     // spread deviation limit
   logic [16:0]         res_r;        // resistor control bits
   acq_state_t          acq_state_r;  // acquisition in progress
   logic [7:0]          last_pair_r;  // last pair presented this run
   logic                first_r;      // no pair presented yet this run
   logic                cal_d_r;      // calibration level, delayed
   logic [8:0]          lfsr_r;       // pseudo random deviation source
   logic [31:0]         set_w;        // hardware set terms
   logic [31:0]         clr_w;        // software clear terms
   logic                take_w;       // offer accepted this cycle
   logic                keep_w;       // accepted offer is presented
   logic                pop_w;        // software read the count word
   logic [31:0]         status_w;     // status word as read

   // ****************************************
   // read mux
   // ****************************************
   // status bits 0 and 1 are live levels; the rest are the sticky flags
   always_comb begin
      status_w = flags_r & `TA_EVENT_BITS;
      // (R1) live calibration level
      status_w[`TA_BIT_CALIBRATING] = calibrating;
      // (R2) live enable level
      status_w[`TA_BIT_ENABLED] = module_enabled;
   end

   always_comb begin
      mapped_w = 1'b1;
      rd_mux_w = `TA_RESET_WORD;
      unique case (paddr)
         `TA_OFS_STATUS_WORD: rd_mux_w = status_w;
         // write-only registers read as zero
         `TA_OFS_STATUS_CLEAR, `TA_OFS_IRQ_SET, `TA_OFS_IRQ_CLEAR: rd_mux_w = `TA_RESET_WORD;
         `TA_OFS_IRQ_MASK:    rd_mux_w = mask_r;
         // (R10) read back selection
         `TA_OFS_ACQ_START:   rd_mux_w = {30'h0, sel_r};
         // (R11) pair above count
         `TA_OFS_ACQ_COUNT:   rd_mux_w = {8'h00, count_r.pair, count_r.count};
         `TA_OFS_SPREAD_CFG:  rd_mux_w = {24'h0, burst_max_deviation_r};
         `TA_OFS_RES_CTRL:    rd_mux_w = {15'h0, res_r};
         default:             mapped_w = 1'b0;
      endcase
   end

   // ****************************************
   // apb answer
   // ****************************************
   // answer in the first access cycle: no wait states
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `TA_RESET_WORD;
      end else begin
         pready  <= setup_w;
         pslverr <= setup_w && !mapped_w;
         if (setup_w) begin
            prdata <= pwrite ? `TA_RESET_WORD : rd_mux_w;
         end
      end
   end

   // ****************************************
   // software writable configuration
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sel_r    <= 2'h0;
         burst_max_deviation_r <= 8'h00;
         res_r    <= 17'h0_0000;
      end else if (wr_w) begin
         // codes 10 and 11 are stored and passed on as written
         if (paddr == `TA_OFS_ACQ_START) begin
            sel_r <= pwdata[1:0];
         end
         if (paddr == `TA_OFS_SPREAD_CFG) begin
            burst_max_deviation_r <= pwdata[7:0];
         end
         if (paddr == `TA_OFS_RES_CTRL) begin
            res_r <= pwdata[16:0];
         end
      end
   end

   // ****************************************
   // interrupt mask
   // ****************************************
   // (R5) (R6) (R4) ones set or clear, zeros ignored
   assign mask_nxt = (wr_w && paddr == `TA_OFS_IRQ_SET) ? (mask_r | (pwdata & `TA_EVENT_BITS)) :
                     (wr_w && paddr == `TA_OFS_IRQ_CLEAR) ? (mask_r & ~pwdata) : mask_r;
   // (R7) mask resets to zero
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mask_r <= `TA_RESET_WORD;
      end else begin
         mask_r <= mask_nxt;
      end
   end

   // ****************************************
   // acquisition sequencing
   // ****************************************
   // (R9) any write to the start register launches a run
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         acq_state_r       <= ACQ_IDLE;
         acq_start         <= 1'b0;
         group_select_code <= 2'h0;
      end else begin
         acq_start <= wr_w && paddr == `TA_OFS_ACQ_START;
         if (wr_w && paddr == `TA_OFS_ACQ_START) begin
            acq_state_r       <= ACQ_RUN;
            group_select_code <= pwdata[1:0];
         end else if (acq_complete) begin
            acq_state_r <= ACQ_IDLE;
         end
      end
   end

   // ****************************************
   // count offers
   // ****************************************
   // one count is held at a time; the engine waits while software has not read it
   assign pop_w  = rd_w && paddr == `TA_OFS_ACQ_COUNT;
   assign take_w = count_offer_valid && !count_take && !flags_r[`TA_BIT_COUNT_READY];
   // (R12) only enabled pairs beyond the last one are presented
   assign keep_w = take_w && pair_enable[count_offer.pair[$clog2(PAIRS)-1:0]]
                   && (first_r || count_offer.pair > last_pair_r);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         count_r     <= '0;
         count_take  <= 1'b0;
         last_pair_r <= 8'h00;
         first_r     <= 1'b1;
      end else begin
         // dropped offers are still taken so the engine moves on
         count_take <= take_w;
         // a restart wins over a keep, but the kept word is still presented with its flag
         first_r    <= (wr_w && paddr == `TA_OFS_ACQ_START) || (first_r && !keep_w);
         if (keep_w) begin
            count_r     <= count_offer;
            last_pair_r <= count_offer.pair;
         end
      end
   end

   // ****************************************
   // sticky status flags
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cal_d_r <= 1'b0;
      end else begin
         cal_d_r <= calibrating;
      end
   end

   always_comb begin
      set_w = `TA_RESET_WORD;
      set_w[`TA_BIT_CALIBRATING]   = calibrating && !cal_d_r;
      set_w[`TA_BIT_AUTO_CHANGE]   = auto_status_change;
      set_w[`TA_BIT_ASSIST_CHANGE] = assist_state_change;
      // (R15) count ready on a kept offer
      set_w[`TA_BIT_COUNT_READY]   = keep_w;
      // (R16) done on completion of a run
      set_w[`TA_BIT_ACQ_DONE]      = acq_complete && acq_state_r == ACQ_RUN;
      // (R3) ones clear flags, (R4) zeros ignored
      clr_w = (wr_w && paddr == `TA_OFS_STATUS_CLEAR) ? pwdata : `TA_RESET_WORD;
      // reading the count word consumes it
      clr_w[`TA_BIT_COUNT_READY] = clr_w[`TA_BIT_COUNT_READY] || pop_w;
      // (R16) done drops when a run starts
      clr_w[`TA_BIT_ACQ_DONE] = clr_w[`TA_BIT_ACQ_DONE] || (wr_w && paddr == `TA_OFS_ACQ_START);
   end

   // a set in the same cycle as a clear wins, so no event is lost
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         flags_r <= `TA_RESET_WORD;
      end else begin
         flags_r <= ((flags_r & ~clr_w) | set_w) & `TA_EVENT_BITS;
      end
   end

   // ****************************************
   // interrupt output
   // ****************************************
   // (R8) unmasked flag drives irq
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((flags_r & ~clr_w) | set_w) & mask_nxt & `TA_EVENT_BITS);
      end
   end

   // ****************************************
   // spread spectrum deviation
   // ****************************************
   // a fresh deviation per burst pulse; magnitude clamped, so it is not uniform
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lfsr_r       <= `TA_LFSR_SEED;
         dev_negative <= 1'b0;
         dev_cycles   <= 8'h00;
      end else if (burst_pulse) begin
         lfsr_r       <= {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
         dev_negative <= spread_enable && lfsr_r[8];
         // (R13) clamp to configured maximum
         if (!spread_enable) begin
            dev_cycles <= 8'h00;
         end else if (lfsr_r[7:0] > burst_max_deviation_r) begin
            dev_cycles <= burst_max_deviation_r;
         end else begin
            dev_cycles <= lfsr_r[7:0];
         end
      end
   end

   // ****************************************
   // resistive drive select
   // ****************************************
   // (R14) per-pin resistive drive in burst
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         burst_pin_bank_a_res <= 17'h0_0000;
      end else begin
         burst_pin_bank_a_res <= burst_phase ? res_r : 17'h0_0000;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   sequence s_clear_write;
      wr_w && paddr == `TA_OFS_STATUS_CLEAR && pwdata[`TA_BIT_AUTO_CHANGE] && !auto_status_change;
   endsequence

   sequence s_start_write;
      wr_w && paddr == `TA_OFS_ACQ_START;
   endsequence

   property p_cal_level;
      @(posedge ref_clk) disable iff (reset)
      pready && !pwrite && paddr == `TA_OFS_STATUS_WORD |-> prdata[1] == $past(calibrating);
   endproperty
   a_cal_level: assert property (p_cal_level) else $error("calibrating bit wrong"); // (R1)

   property p_clear;
      @(posedge ref_clk) disable iff (reset)
      s_clear_write |=> !flags_r[`TA_BIT_AUTO_CHANGE];
   endproperty
   a_clear: assert property (p_clear) else $error("status clear failed"); // (R3)

   property p_mask_set;
      @(posedge ref_clk) disable iff (reset)
      wr_w && paddr == `TA_OFS_IRQ_SET |=> (mask_r & ($past(pwdata) & `TA_EVENT_BITS)) == ($past(pwdata) & `TA_EVENT_BITS);
   endproperty
   a_mask_set: assert property (p_mask_set) else $error("mask set failed"); // (R5)

   property p_mask_clr;
      @(posedge ref_clk) disable iff (reset)
      wr_w && paddr == `TA_OFS_IRQ_CLEAR |=> (mask_r & $past(pwdata)) == 32'h0000_0000;
   endproperty
   a_mask_clr: assert property (p_mask_clr) else $error("mask clear failed"); // (R6)

   property p_irq;
      @(posedge ref_clk) disable iff (reset)
      ##1 irq == |(flags_r & mask_r);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt level wrong"); // (R8)

   property p_start;
      @(posedge ref_clk) disable iff (reset)
      s_start_write |=> acq_start && group_select_code == $past(pwdata[1:0]) ##1 !acq_start;
   endproperty
   a_start: assert property (p_start) else $error("start pulse wrong"); // (R9)

   property p_done_low;
      @(posedge ref_clk) disable iff (reset)
      wr_w && paddr == `TA_OFS_ACQ_START && !acq_complete |=> !flags_r[`TA_BIT_ACQ_DONE];
   endproperty
   a_done_low: assert property (p_done_low) else $error("done not cleared at start"); // (R16)

   property p_ready;
      @(posedge ref_clk) disable iff (reset)
      keep_w |=> flags_r[`TA_BIT_COUNT_READY] && count_r == $past(count_offer);
   endproperty
   a_ready: assert property (p_ready) else $error("count not presented"); // (R15)

   property p_order;
      @(posedge ref_clk) disable iff (reset)
      $changed(count_r) && !$past(first_r) |->
         count_r.pair > $past(count_r.pair) && pair_enable[count_r.pair[$clog2(PAIRS)-1:0]];
   endproperty
   a_order: assert property (p_order) else $error("pair order broken"); // (R12)

   property p_dev;
      @(posedge ref_clk) disable iff (reset)
      ##1 dev_cycles <= $past(burst_max_deviation_r) || !$past(burst_pulse);
   endproperty
   a_dev: assert property (p_dev) else $error("deviation above maximum"); // (R13)

endmodule

`default_nettype wire

// >>> test/touch_engine_model.sv
// Purpose: behavioural acquisition engine on the far side of the control block
// Assumes: one fixed pair sequence per run, count word tagged with the group code
// Notes:   gap slows the engine; released offer lines show inverted data
`timescale 1ns/1ns
`default_nettype none

module touch_engine_model (
   // clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      reset,
   // control from the block
   input  wire logic                      acq_start,
   input  wire logic [1:0]                group_select_code,
   input  wire logic                      count_take,
   input  wire logic [3:0]                gap,
   // offers and completion
   output var  logic                      count_offer_valid,
   output var  touch_acq_pkg::acq_count_t count_offer,
   output var  logic                      acq_complete
);
   import touch_acq_pkg::*;

   // ****************************************
   // pair sequence of one run
   // ****************************************
   // disabled, repeated and falling pairs are mixed in so the block must drop them
   localparam logic [7:0] SEQ [6] = '{8'h01, 8'h03, 8'h04, 8'h04, 8'h02, 8'h09};

   // one run per start pulse, offers held until taken
   initial begin
      count_offer_valid = 1'b0;
      count_offer = '0;
      acq_complete = 1'b0;
      forever begin
         @(posedge ref_clk);
         if (acq_start === 1'b1 && reset === 1'b0) begin
            for (int i = 0; i < 6; i++) begin
               // two idle cycles at least after each take
               repeat (2 + gap) @(posedge ref_clk);
               count_offer_valid <= 1'b1;
               count_offer <= '{pair: SEQ[i], count: {6'h00, group_select_code, SEQ[i]}};
               do @(posedge ref_clk); while (count_take !== 1'b1);
               count_offer_valid <= 1'b0;
               // stale data must not look valid after release
               count_offer <= acq_count_t'(~count_offer);
            end
            repeat (gap + 1) @(posedge ref_clk);
            acq_complete <= 1'b1;
            @(posedge ref_clk);
            acq_complete <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> test/touch_acq_control_interface_tb.sv
// Purpose: self-checking bench of the touch acquisition control block
// Assumes: zero-wait APB slave, engine model on the far side
// Notes:   expected words are built from the register layout, never read back
`timescale 1ns/1ns
`include "touch_acq_regs.svh"
`default_nettype none

module touch_acq_control_interface_tb;
   import touch_acq_pkg::*;

   // ****************************************
   // design pins
   // ****************************************
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, irq, acq_start, count_take, count_offer_valid, acq_complete;
   logic        module_enabled = 1'b0, calibrating = 1'b0;
   logic        auto_status_change = 1'b0, assist_state_change = 1'b0;
   logic [31:0] pair_enable = 32'h0000_0212;  // pairs 1, 4 and 9
   logic        spread_enable = 1'b0, burst_pulse = 1'b0, burst_phase = 1'b0, dev_negative;
   logic [1:0]  group_select_code;
   logic [7:0]  dev_cycles;
   logic [16:0] burst_pin_bank_a_res;
   logic [3:0]  gap = 4'h0;                   // engine slowness
   acq_count_t  count_offer;
   int          errors = 0, checks = 0, cyc = 0;
   logic [31:0] rdat;
   logic        serr;

   // 250 MHz
   always #2 ref_clk = ~ref_clk;

   touch_acq_control_interface #(.PAIRS(32)) i_touch_acq_control_interface (
      .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .module_enabled(module_enabled), .calibrating(calibrating),
      .auto_status_change(auto_status_change), .assist_state_change(assist_state_change),
      .pair_enable(pair_enable), .acq_start(acq_start), .group_select_code(group_select_code),
      .acq_complete(acq_complete), .count_offer_valid(count_offer_valid), .count_offer(count_offer),
      .count_take(count_take), .spread_enable(spread_enable), .burst_pulse(burst_pulse),
      .burst_phase(burst_phase), .dev_negative(dev_negative), .dev_cycles(dev_cycles),
      .burst_pin_bank_a_res(burst_pin_bank_a_res), .irq(irq));

   touch_engine_model i_touch_engine_model (
      .ref_clk(ref_clk), .reset(reset), .acq_start(acq_start), .group_select_code(group_select_code),
      .count_take(count_take), .gap(gap), .count_offer_valid(count_offer_valid),
      .count_offer(count_offer), .acq_complete(acq_complete));

   // ****************************************
   // reporting
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // hang guard, the whole run needs a few hundred cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         wrap_up();
      end
   end

   // ****************************************
   // apb master
   // ****************************************
   // request held until pready is sampled high, then released
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic se);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, rdat, serr);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0, rdat, serr);
      chk(rdat, exp);
   endtask

   // irq is registered, so let two edges pass first
   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'(exp));
   endtask

   // bounded poll of one status bit
   task automatic wait_bit(input int b);
      logic [31:0] s;
      logic        e;
      s = 32'h0;
      for (int n = 0; n < 100 && s[b] !== 1'b1; n++)
         xfer(1'b0, `TA_OFS_STATUS_WORD, 32'h0, s, e);
   endtask

   // one group run: only pairs 1, 4, 9 may come out, in that order
   // done is left set unless clr, so the next start must drop it
   task automatic run_group(input logic [1:0] code, input logic [3:0] g, input logic clr);
      logic [7:0] p;
      gap <= g;
      wr(`TA_OFS_ACQ_START, {30'h0, code});
      rd_chk(`TA_OFS_STATUS_WORD, 32'h0000_0001);
      irq_chk(1'b0);
      rd_chk(`TA_OFS_ACQ_START, {30'h0, code});
      chk(32'(group_select_code), 32'(code));
      for (int i = 0; i < 3; i++) begin
         p = (i == 0) ? 8'h01 : (i == 1) ? 8'h04 : 8'h09;
         wait_bit(`TA_BIT_COUNT_READY);
         rd_chk(`TA_OFS_ACQ_COUNT, {8'h00, p, 6'h00, code, p});
      end
      wait_bit(`TA_BIT_ACQ_DONE);
      rd_chk(`TA_OFS_STATUS_WORD, 32'h0000_0201);
      irq_chk(1'b1);
      if (clr) begin
         wr(`TA_OFS_STATUS_CLEAR, 32'h0000_0200);
         irq_chk(1'b0);
      end
      $display("test done: group run code %0d", code);
   endtask

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      rd_chk(`TA_OFS_IRQ_MASK, 32'h0);
      rd_chk(`TA_OFS_ACQ_START, 32'h0);
      rd_chk(`TA_OFS_ACQ_COUNT, 32'h0);
      rd_chk(`TA_OFS_RES_CTRL, 32'h0);
      xfer(1'b0, 8'h70, 32'h0, rdat, serr);
      chk(32'(serr), 32'h1);
      $display("test done: reset values");
      // live level bits
      module_enabled <= 1'b1;
      calibrating <= 1'b1;
      @(posedge ref_clk);
      rd_chk(`TA_OFS_STATUS_WORD, 32'h0000_0003);
      calibrating <= 1'b0;
      @(posedge ref_clk);
      rd_chk(`TA_OFS_STATUS_WORD, 32'h0000_0001);
      $display("test done: live status");
      // event flag, mask set and clear, zero writes
      auto_status_change <= 1'b1;
      @(posedge ref_clk);
      auto_status_change <= 1'b0;
      rd_chk(`TA_OFS_STATUS_WORD, 32'h0000_0005);
      irq_chk(1'b0);
      wr(`TA_OFS_IRQ_SET, 32'h0000_0004);
      rd_chk(`TA_OFS_IRQ_MASK, 32'h0000_0004);
      irq_chk(1'b1);
      wr(`TA_OFS_STATUS_CLEAR, 32'h0);
      wr(`TA_OFS_IRQ_CLEAR, 32'h0);
      wr(`TA_OFS_IRQ_SET, 32'h0);
      rd_chk(`TA_OFS_STATUS_WORD, 32'h0000_0005);
      rd_chk(`TA_OFS_IRQ_MASK, 32'h0000_0004);
      wr(`TA_OFS_IRQ_CLEAR, 32'h0000_0004);
      rd_chk(`TA_OFS_IRQ_MASK, 32'h0);
      irq_chk(1'b0);
      wr(`TA_OFS_IRQ_SET, 32'hFFFF_FFFF);
      rd_chk(`TA_OFS_IRQ_MASK, `TA_EVENT_BITS);
      wr(`TA_OFS_STATUS_CLEAR, 32'h0000_0004);
      rd_chk(`TA_OFS_STATUS_WORD, 32'h0000_0001);
      irq_chk(1'b1);
      wr(`TA_OFS_STATUS_CLEAR, 32'h0000_0002);
      irq_chk(1'b0);
      assist_state_change <= 1'b1;
      @(posedge ref_clk);
      assist_state_change <= 1'b0;
      rd_chk(`TA_OFS_STATUS_WORD, 32'h0080_0001);
      irq_chk(1'b1);
      wr(`TA_OFS_STATUS_CLEAR, 32'h0080_0000);
      irq_chk(1'b0);
      wr(`TA_OFS_IRQ_CLEAR, 32'hFFFF_FFFF);
      wr(`TA_OFS_IRQ_SET, 32'h0000_0200);
      $display("test done: interrupts");
      // both defined group codes, prompt and slow engine; the second start must drop done
      run_group(2'b01, 4'h0, 1'b0);
      run_group(2'b00, 4'h5, 1'b1);
      // burst deviation bound
      wr(`TA_OFS_SPREAD_CFG, 32'h0000_0003);
      rd_chk(`TA_OFS_SPREAD_CFG, 32'h0000_0003);
      spread_enable <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         burst_pulse <= 1'b1;
         @(posedge ref_clk);
         burst_pulse <= 1'b0;
         repeat (2) @(posedge ref_clk);
         chk(32'(dev_cycles > 8'h03), 32'h0);
      end
      // spread disabled: no deviation in either direction
      spread_enable <= 1'b0;
      burst_pulse <= 1'b1;
      @(posedge ref_clk);
      burst_pulse <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk({23'h0, dev_negative, dev_cycles}, 32'h0);
      // resistive drive only in the burst phase
      wr(`TA_OFS_RES_CTRL, 32'h0001_5A5A);
      rd_chk(`TA_OFS_RES_CTRL, 32'h0001_5A5A);
      burst_phase <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk(32'(burst_pin_bank_a_res), 32'h0001_5A5A);
      burst_phase <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk(32'(burst_pin_bank_a_res), 32'h0);
      $display("test done: burst drive");
      wrap_up();
   end
endmodule
`default_nettype wire
